// ==== verilog/ffp_pkg.sv ====
package ffp_pkg;

  // Clock rate and derived timing counts
  localparam int unsigned CLK_PERIOD_NS = 10;

  localparam int unsigned OVP_SUPPLY_DEBOUNCE_US = 100;
  localparam int unsigned OVP_SUPPLY_DEBOUNCE_CYC =
    OVP_SUPPLY_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned LINE_OUT_DEBOUNCE_US = 100;
  localparam int unsigned LINE_OUT_DEBOUNCE_CYC =
    LINE_OUT_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned OVERLOAD_DEBOUNCE_US = 100;
  localparam int unsigned OVERLOAD_DEBOUNCE_CYC =
    OVERLOAD_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned LONG_RESTART_OFF_US = 1000;
  localparam int unsigned LONG_RESTART_OFF_CYC =
    LONG_RESTART_OFF_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned UV_BLANK_US = 100;
  localparam int unsigned UV_BLANK_CYC = UV_BLANK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SSP_BLANK_NS = 200;
  localparam int unsigned SSP_BLANK_CYC =
    (SSP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SENSE_SHORT_DEB_NS = 300;
  localparam int unsigned SENSE_SHORT_DEB_CYC =
    (SENSE_SHORT_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ONTIME_LIMIT_NS = 1000;
  localparam int unsigned ONTIME_LIMIT_CYC = ONTIME_LIMIT_NS / CLK_PERIOD_NS;
  localparam int unsigned DEMAG_SAMPLE_BLANK_NS = 500;
  localparam int unsigned DEMAG_SAMPLE_BLANK_CYC =
    (DEMAG_SAMPLE_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Switching-cycle counts
  localparam logic [3:0] LINE_IN_CYCLES        = 4'h4;
  localparam logic [3:0] DEMAG_OV_CYCLES_DEF   = 4'h3;
  localparam logic [3:0] DEMAG_UV_CYCLES_DEF   = 4'h3;
  localparam logic [3:0] SENSE_SHORT_CYCLES    = 4'h4;
  localparam logic [3:0] SECONDARY_SHORT_CYCLES = 4'h4;

  localparam int unsigned TMR_W = 24;
  localparam int unsigned CYC_W = 4;

  // Protection modes
  typedef enum logic [1:0] {
    FFP_MODE_NONE = 2'b00,
    FFP_MODE_AR   = 2'b01,
    FFP_MODE_LAR  = 2'b10,
    FFP_MODE_LATCH = 2'b11
  } ffp_mode_t;

  typedef enum logic [2:0] {
    FFP_ST_CHARGE  = 3'b000,
    FFP_ST_LINEIN  = 3'b001,
    FFP_ST_RUN     = 3'b010,
    FFP_ST_AR      = 3'b011,
    FFP_ST_LAR     = 3'b100,
    FFP_ST_LATCH   = 3'b101
  } ffp_state_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic supply_on;        // supply at or above turn-on level
    logic supply_ok;        // supply above operating level
    logic supply_ov;        // supply above overvoltage level
    logic cs_limit;         // current sense at limit level
    logic cs_sense_short;   // current sense below sense-short threshold
    logic cs_secondary;     // current sense at secondary-short threshold
    logic fb_overload;      // feedback at overload level
    logic demag_line_in;    // demag current above line-in threshold
    logic demag_line_out;   // demag current below line-out threshold
    logic demag_ov;         // demag voltage above overvoltage level
    logic demag_uv;         // demag voltage below undervoltage level
    logic over_temp;
  } ffp_sense_t;

  // Fault flags
  typedef struct packed {
    logic supply_overvoltage_fault;
    logic line_drop_fault;
    logic demag_overvoltage_fault;
    logic demag_undervoltage_fault;
    logic sense_short_fault;
    logic secondary_short_fault;
    logic overload_fault;
    logic over_temp_fault;
    logic no_line_in_fault;
  } ffp_fault_t;

endpackage : ffp_pkg

// ==== verilog/ffp_protect.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Current sense at limit ends the on-pulse one clock after its two-stage synchronised sample, every cycle.
// - Start-up path on while supply charges; off and switching at turn-on level.
// - After switching starts, no line-in detected means auto-restart.
// - Option selects auto-restart or latch for demag overvoltage.
// - Option selects auto-restart or long auto-restart for demag undervoltage.
// - Long restart holds switch off for its time, resumes at turn-on.
// - Supply over overvoltage level for debounce time gives fault, auto-restart.
// - Line-in valid after current exceeds threshold for consecutive conducting cycles.
// - Demag current below line-out threshold past debounce gives line-drop fault.
// - Over-temperature disables the gate and enters protection.
// - Demag overvoltage over cycle count stops pulses, auto-restart or latch.
// - Demag undervoltage over cycle count trips, auto-restart or long restart.
// - Demag undervoltage ignored during start-up blanking after power-on.
// - Sense still below sense-short threshold after debounce limits on-time.
// - Sense-short persisting the cycle count enters auto-restart.
// - After short blanking, secondary-short threshold turns switch off.
// - Secondary-short persisting the cycle count enters auto-restart.
// - Overload timer starts when feedback reaches overload level in run state.
// - Overload timer past debounce time shuts down, auto-restart.
// - Feedback below overload level before expiry clears the timer.
// - Demag voltage sampled at end of demag sampling blanking each cycle.
module ffp_protect (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Configuration
  input  wire logic             cfg_ovp_latch,
  input  wire logic             cfg_uvp_long,
  input  wire logic [3:0]       cfg_demag_ov_cycles,
  input  wire logic [3:0]       cfg_demag_uv_cycles,
  // Analog comparators and loop demand
  input  wire ffp_pkg::ffp_sense_t sense_in,
  input  wire logic             pwm_demand,
  // Outputs
  output logic                  gate_en,
  output logic                  hv_start_en,
  output ffp_pkg::ffp_mode_t    prot_mode,
  output ffp_pkg::ffp_fault_t   fault_flags,
  output logic                  demag_sample
);
  import ffp_pkg::*;

  ffp_sense_t sync1_q, s_q;
  logic       dem_q1, dem_q;
  ffp_state_t state_q, state_d;
  ffp_fault_t fault_d, fault_q;
  logic       gate_q, gate_prev_q, on_start, on_end;
  logic [TMR_W-1:0] on_tmr_q, off_tmr_q, ovs_tmr_q, lo_tmr_q, ol_tmr_q, blank_tmr_q;
  logic [CYC_W-1:0] li_cnt_q, ov_cnt_q, uv_cnt_q, ss_cnt_q, sec_cnt_q;
  logic       cyc_ov_q, cyc_uv_q, cyc_ss_q, cyc_sec_q, cyc_li_q;
  logic       line_in_q, blank_done;
  logic       trip_ar, trip_lar, trip_latch, any_trip;
  logic [TMR_W-1:0] lar_tmr_q;
  logic             lar_done;

  // Two-stage synchronisers for all analog inputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      s_q     <= '0;
      dem_q1  <= 1'b0;
      dem_q   <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= sense_in;
      s_q     <= sync1_q;
      dem_q1  <= pwm_demand;
      dem_q   <= dem_q1;
    end
  end

  assign on_start   = gate_q && !gate_prev_q;
  assign on_end     = !gate_q && gate_prev_q;
  assign blank_done = (blank_tmr_q == TMR_W'(UV_BLANK_CYC));

  // Switch gate: ends on limit, secondary short or on-time cap
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_q      <= 1'b0;
      gate_prev_q <= 1'b0;
      on_tmr_q    <= '0;
    end else if (clk_en) begin
      gate_prev_q <= gate_q;
      if (state_q != FFP_ST_RUN && state_q != FFP_ST_LINEIN) begin
        gate_q   <= 1'b0;
        on_tmr_q <= '0;
      end else if (gate_q) begin
        on_tmr_q <= on_tmr_q + 1'b1;
        if (s_q.cs_limit || !dem_q) begin
          gate_q <= 1'b0;
        end else if (s_q.cs_secondary && on_tmr_q >= TMR_W'(SSP_BLANK_CYC)) begin
          gate_q <= 1'b0;
        end else if (s_q.cs_sense_short && on_tmr_q >= TMR_W'(SENSE_SHORT_DEB_CYC)
                     && on_tmr_q >= TMR_W'(ONTIME_LIMIT_CYC)) begin
          gate_q <= 1'b0;
        end
      end else begin
        on_tmr_q <= '0;
        // New pulse only after the demag sample; stale limit samples are flushed by then
        gate_q   <= dem_q && !any_trip && !s_q.cs_limit &&
                    off_tmr_q == TMR_W'(DEMAG_SAMPLE_BLANK_CYC);
      end
    end
  end

  // Per-pulse observations: shorts and line-in latched within the on-time, demag ov/uv at the sample strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_ov_q  <= 1'b0;
      cyc_uv_q  <= 1'b0;
      cyc_ss_q  <= 1'b0;
      cyc_sec_q <= 1'b0;
      cyc_li_q  <= 1'b0;
    end else if (clk_en) begin
      if (on_start) begin
        cyc_ss_q  <= 1'b0;
        cyc_sec_q <= 1'b0;
        cyc_li_q  <= 1'b0;
      end else if (gate_q) begin
        if (s_q.demag_line_in) cyc_li_q <= 1'b1;
        if (s_q.cs_secondary && on_tmr_q >= TMR_W'(SSP_BLANK_CYC)) cyc_sec_q <= 1'b1;
        if (s_q.cs_sense_short && on_tmr_q >= TMR_W'(SENSE_SHORT_DEB_CYC)) begin
          cyc_ss_q <= 1'b1;
        end
      end
      if (demag_sample) begin
        cyc_ov_q <= s_q.demag_ov;
        cyc_uv_q <= s_q.demag_uv;
      end
    end
  end

  // Demag sample strobe at the end of sampling blanking after turn-off
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      off_tmr_q    <= '0;
      demag_sample <= 1'b0;
    end else if (clk_en) begin
      demag_sample <= 1'b0;
      if (gate_q || on_end) begin
        off_tmr_q <= '0;
      end else if (off_tmr_q < TMR_W'(DEMAG_SAMPLE_BLANK_CYC)) begin
        off_tmr_q <= off_tmr_q + 1'b1;
        if (off_tmr_q == TMR_W'(DEMAG_SAMPLE_BLANK_CYC - 1)) begin
          demag_sample <= 1'b1;
        end
      end
    end
  end

  // Consecutive switching-cycle counters, advanced at each turn-off
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      li_cnt_q  <= '0;
      ov_cnt_q  <= '0;
      uv_cnt_q  <= '0;
      ss_cnt_q  <= '0;
      sec_cnt_q <= '0;
      line_in_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == FFP_ST_CHARGE) begin
        li_cnt_q  <= '0;
        ov_cnt_q  <= '0;
        uv_cnt_q  <= '0;
        ss_cnt_q  <= '0;
        sec_cnt_q <= '0;
        line_in_q <= 1'b0;
      end else if (on_end) begin
        li_cnt_q  <= (cyc_li_q || s_q.demag_line_in) ? li_cnt_q + 1'b1 : '0;
        if ((cyc_li_q || s_q.demag_line_in) && li_cnt_q + 1'b1 >= LINE_IN_CYCLES) begin
          line_in_q <= 1'b1;
        end
        ov_cnt_q  <= cyc_ov_q ? ov_cnt_q + 1'b1 : '0;
        uv_cnt_q  <= (cyc_uv_q && blank_done) ? uv_cnt_q + 1'b1 : '0;
        ss_cnt_q  <= cyc_ss_q ? ss_cnt_q + 1'b1 : '0;
        sec_cnt_q <= cyc_sec_q ? sec_cnt_q + 1'b1 : '0;
      end
    end
  end

  // Time-based debounce timers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovs_tmr_q   <= '0;
      lo_tmr_q    <= '0;
      ol_tmr_q    <= '0;
      blank_tmr_q <= '0;
    end else if (clk_en) begin
      ovs_tmr_q <= s_q.supply_ov ? ovs_tmr_q + 1'b1 : '0;
      lo_tmr_q  <= (s_q.demag_line_out && line_in_q) ? lo_tmr_q + 1'b1 : '0;
      ol_tmr_q  <= (s_q.fb_overload && state_q == FFP_ST_RUN) ?
                   ol_tmr_q + 1'b1 : '0;
      if (state_q == FFP_ST_CHARGE) blank_tmr_q <= '0;
      else if (!blank_done) blank_tmr_q <= blank_tmr_q + 1'b1;
    end
  end

  // Fault detection and mode selection
  always_comb begin
    fault_d = '0;
    fault_d.supply_overvoltage_fault = ovs_tmr_q >= TMR_W'(OVP_SUPPLY_DEBOUNCE_CYC);
    fault_d.line_drop_fault  = lo_tmr_q > TMR_W'(LINE_OUT_DEBOUNCE_CYC);
    fault_d.demag_overvoltage_fault  = ov_cnt_q > cfg_demag_ov_cycles;
    fault_d.demag_undervoltage_fault = uv_cnt_q > cfg_demag_uv_cycles;
    fault_d.sense_short_fault     = ss_cnt_q >= SENSE_SHORT_CYCLES;
    fault_d.secondary_short_fault = sec_cnt_q >= SECONDARY_SHORT_CYCLES;
    fault_d.overload_fault   = ol_tmr_q > TMR_W'(OVERLOAD_DEBOUNCE_CYC);
    fault_d.over_temp_fault  = s_q.over_temp;
    fault_d.no_line_in_fault = state_q == FFP_ST_LINEIN && on_end &&
                               li_cnt_q == '0 && !cyc_li_q && blank_done;
    trip_latch = fault_d.demag_overvoltage_fault && cfg_ovp_latch;
    trip_lar   = fault_d.demag_undervoltage_fault && cfg_uvp_long;
    trip_ar    = fault_d.supply_overvoltage_fault || fault_d.line_drop_fault ||
                 (fault_d.demag_overvoltage_fault && !cfg_ovp_latch) ||
                 (fault_d.demag_undervoltage_fault && !cfg_uvp_long) ||
                 fault_d.sense_short_fault || fault_d.secondary_short_fault ||
                 fault_d.overload_fault || fault_d.over_temp_fault ||
                 fault_d.no_line_in_fault;
    any_trip   = trip_ar || trip_lar || trip_latch;
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FFP_ST_CHARGE: if (s_q.supply_on) state_d = FFP_ST_LINEIN;
      FFP_ST_LINEIN, FFP_ST_RUN: begin
        if (trip_latch) state_d = FFP_ST_LATCH;
        else if (trip_lar) state_d = FFP_ST_LAR;
        else if (trip_ar) state_d = FFP_ST_AR;
        else if (line_in_q) state_d = FFP_ST_RUN;
      end
      FFP_ST_AR: if (!s_q.supply_on) state_d = FFP_ST_CHARGE;
      FFP_ST_LAR: if (lar_done) state_d = FFP_ST_CHARGE;
      FFP_ST_LATCH: state_d = FFP_ST_LATCH;
      default: state_d = FFP_ST_CHARGE;
    endcase
  end

  assign lar_done = lar_tmr_q >= TMR_W'(LONG_RESTART_OFF_CYC);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lar_tmr_q <= '0;
    end else if (clk_en) begin
      if (state_q != FFP_ST_LAR) lar_tmr_q <= '0;
      else if (!lar_done) lar_tmr_q <= lar_tmr_q + 1'b1;
    end
  end

  // State, registered outputs; latch left only by supply loss reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= FFP_ST_CHARGE;
      fault_q     <= '0;
      hv_start_en <= 1'b1;
      prot_mode   <= FFP_MODE_NONE;
    end else if (clk_en) begin
      if (state_q == FFP_ST_LATCH && !s_q.supply_ok) state_q <= FFP_ST_CHARGE;
      else state_q <= state_d;
      fault_q     <= fault_q | fault_d;
      if (state_d == FFP_ST_LINEIN && state_q == FFP_ST_CHARGE) fault_q <= fault_d;
      hv_start_en <= (state_d == FFP_ST_CHARGE) || (state_d == FFP_ST_AR) ||
                     (state_d == FFP_ST_LAR && lar_done);
      unique case (state_d)
        FFP_ST_AR:    prot_mode <= FFP_MODE_AR;
        FFP_ST_LAR:   prot_mode <= FFP_MODE_LAR;
        FFP_ST_LATCH: prot_mode <= FFP_MODE_LATCH;
        default:      prot_mode <= FFP_MODE_NONE;
      endcase
    end
  end

  assign gate_en     = gate_q;
  assign fault_flags = fault_q;

endmodule : ffp_protect

// ==== testbench/ffp_protect_properties.sv ====
`timescale 1ns/100ps
module ffp_protect_properties
  import ffp_pkg::*;
(
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic                clk_en,
  // Watched ports
  input wire ffp_pkg::ffp_sense_t sense_in,
  input wire logic                gate_en,
  input wire logic                hv_start_en,
  input wire ffp_pkg::ffp_mode_t  prot_mode,
  input wire ffp_pkg::ffp_fault_t fault_flags,
  input wire logic                demag_sample
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_limit_held;
    (sense_in.cs_limit && clk_en) [*3];
  endsequence
  sequence s_hot_held;
    (sense_in.over_temp && clk_en) [*5];
  endsequence
  sequence s_latch_held;
    (prot_mode == FFP_MODE_LATCH && sense_in.supply_ok) [*4];
  endsequence

  AST_CS_LIMIT: assert property (s_limit_held |=> !gate_en)
    else $error("gate stays on at current limit");
  AST_HOT_OFF: assert property (s_hot_held |-> !gate_en)
    else $error("gate stays on while hot");
  AST_PROT_OFF: assert property (prot_mode != FFP_MODE_NONE
    && $past(prot_mode) != FFP_MODE_NONE |-> !gate_en)
    else $error("gate on in protection mode");
  AST_LATCH_HOLD: assert property (s_latch_held |=> prot_mode == FFP_MODE_LATCH)
    else $error("latch left with supply still up");
  AST_LATCH_CAUSE: assert property (prot_mode == FFP_MODE_LATCH
    |-> fault_flags.demag_overvoltage_fault)
    else $error("latch without demag overvoltage");
  AST_LONG_CAUSE: assert property (prot_mode == FFP_MODE_LAR
    |-> fault_flags.demag_undervoltage_fault)
    else $error("long restart without demag undervoltage");
  AST_SAMPLE_PULSE: assert property (demag_sample |=> !demag_sample)
    else $error("sample strobe longer than one cycle");
  AST_SAMPLE_OFF: assert property (demag_sample |-> !gate_en && !$past(gate_en, 2))
    else $error("sample strobe while switch conducts");
  AST_HV_CHARGE: assert property (hv_start_en && $past(hv_start_en) |-> !gate_en)
    else $error("switching while start-up path on");
endmodule : ffp_protect_properties

bind ffp_protect ffp_protect_properties ffp_protect_properties_i (
  .sys_clk, .reset_n, .clk_en, .sense_in, .gate_en, .hv_start_en, .prot_mode, .fault_flags,
  .demag_sample
);

// ==== testbench/ffp_plant.sv ====
`timescale 1ns/100ps
module ffp_plant
  import ffp_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                gate_en,
  input  wire ffp_pkg::ffp_sense_t knob,
  input  wire logic [7:0]          ramp,
  output ffp_pkg::ffp_sense_t      sense
);
  logic [7:0] on_cnt_q = 8'h00;

  // Primary current ramps while the switch conducts
  always_ff @(posedge sys_clk) begin
    if (!gate_en)
      on_cnt_q <= 8'h00;
    else if (on_cnt_q != 8'hff)
      on_cnt_q <= on_cnt_q + 8'h01;
  end

  always_comb begin
    sense = knob;
    sense.cs_limit = knob.cs_limit || (gate_en && on_cnt_q >= ramp);
    sense.demag_line_in = knob.demag_line_in && gate_en;
    sense.demag_line_out = !knob.demag_line_in;
  end
endmodule : ffp_plant

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import ffp_pkg::*;
  localparam ffp_sense_t BASE = 12'hc10;
  logic       sys_clk;
  logic       reset_n;
  logic       cfg_ovp_latch;
  logic       cfg_uvp_long;
  logic       gate_en;
  logic       hv_start_en;
  logic       demag_sample;
  logic [7:0] ramp;
  ffp_sense_t knob;
  ffp_sense_t sense_in;
  ffp_mode_t  prot_mode;
  ffp_fault_t fault_flags;
  int         miscompares;
  int         n_checks;
  int         n;

  ffp_protect ffp_protect_i (.sys_clk, .reset_n, .clk_en(1'b1), .cfg_ovp_latch, .cfg_uvp_long,
    .cfg_demag_ov_cycles(4'h3), .cfg_demag_uv_cycles(4'h2), .sense_in, .pwm_demand(1'b1),
    .gate_en, .hv_start_en, .prot_mode, .fault_flags, .demag_sample);
  ffp_plant ffp_plant_i (.sys_clk, .gate_en, .knob, .ramp, .sense(sense_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic cyc(int c);
    repeat (c) @(negedge sys_clk);
  endtask : cyc

  task automatic power_up(ffp_sense_t k);
    reset_n = 1'b0;
    knob = '0;
    cyc(3);
    reset_n = 1'b1;
    cyc(2);
    check("hv_start_en", hv_start_en, 9'h1);
    knob = k;
    cyc(500);
  endtask : power_up

  // Length of the next complete on-pulse in n
  task automatic on_time;
    n = 0;
    while (gate_en === 1'b1 && n < 900) begin
      cyc(1);
      n++;
    end
    while (gate_en !== 1'b1 && n < 1800) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (gate_en === 1'b1 && n < 900) begin
      cyc(1);
      n++;
    end
  endtask : on_time

  task automatic trip(ffp_sense_t k, int lim, ffp_mode_t m, int b);
    knob = k;
    n = 0;
    while (prot_mode === FFP_MODE_NONE && n < lim) begin
      cyc(1);
      n++;
    end
    check("prot_mode", prot_mode, m);
    check("fault_bit", fault_flags[b], 9'h1);
  endtask : trip

  task automatic s_startup;
    power_up(BASE);
    check("hv_start_en", hv_start_en, 9'h0);
    check("prot_mode", prot_mode, FFP_MODE_NONE);
    on_time();
    check("limit_on_time", n <= 27, 9'h1);
    n = 0;
    repeat (600) begin
      cyc(1);
      n += demag_sample;
    end
    check("sample_seen", n > 0, 9'h1);
  endtask : s_startup

  task automatic s_overtemp;
    power_up(BASE);
    trip(BASE | 12'h001, 50, FFP_MODE_AR, 1);
    knob = BASE & ~12'h800;
    cyc(20);
    check("hv_start_en", hv_start_en, 9'h1);
    knob = BASE;
    cyc(20);
    check("fault_flags", fault_flags, 9'h0);
    on_time();
    check("restart_on", n > 0, 9'h1);
  endtask : s_overtemp

  task automatic s_demag_ov;
    for (int l = 0; l < 2; l++) begin
      cfg_ovp_latch = l[0];
      power_up(BASE);
      trip(BASE | 12'h004, 2000, l ? FFP_MODE_LATCH : FFP_MODE_AR, 6);
    end
    knob = BASE & ~12'h800;
    cyc(20);
    knob = BASE;
    cyc(100);
    check("prot_mode", prot_mode, FFP_MODE_LATCH);
    knob = '0;
    cyc(20);
    knob = BASE;
    on_time();
    check("restart_on", n > 0, 9'h1);
  endtask : s_demag_ov

  task automatic s_demag_uv;
    for (int l = 0; l < 2; l++) begin
      cfg_uvp_long = l[0];
      power_up(BASE | 12'h002);
      cyc(5000);
      check("prot_mode", prot_mode, FFP_MODE_NONE);
      trip(BASE | 12'h002, UV_BLANK_CYC, l ? FFP_MODE_LAR : FFP_MODE_AR, 5);
    end
  endtask : s_demag_uv

  // Short excursion must not trip, a full one must
  task automatic debounce(ffp_sense_t k, int d, int b);
    power_up(BASE);
    knob = k;
    cyc(d / 2);
    knob = BASE;
    cyc(10);
    check("prot_mode", prot_mode, FFP_MODE_NONE);
    trip(k, d + 50, FFP_MODE_AR, b);
    check("full_debounce", n >= d - 5, 9'h1);
  endtask : debounce

  task automatic s_supply_ov;
    debounce(BASE | 12'h200, OVP_SUPPLY_DEBOUNCE_CYC, 8);
  endtask : s_supply_ov

  task automatic s_overload;
    debounce(BASE | 12'h020, OVERLOAD_DEBOUNCE_CYC, 2);
  endtask : s_overload

  task automatic s_line;
    power_up(BASE & ~12'h010);
    trip(BASE & ~12'h010, UV_BLANK_CYC, FFP_MODE_AR, 0);
    power_up(BASE);
    trip(BASE & ~12'h010, LINE_OUT_DEBOUNCE_CYC + 500, FFP_MODE_AR, 7);
  endtask : s_line

  task automatic s_shorts;
    ramp = 8'hc8;
    power_up(BASE);
    knob = BASE | 12'h080;
    on_time();
    check("short_on_time", n <= ONTIME_LIMIT_CYC + 6, 9'h1);
    trip(BASE | 12'h080, 3000, FFP_MODE_AR, 4);
    power_up(BASE);
    knob = BASE | 12'h040;
    on_time();
    check("blank_on_time", n >= SSP_BLANK_CYC && n <= SSP_BLANK_CYC + 6, 9'h1);
    trip(BASE | 12'h040, 3000, FFP_MODE_AR, 3);
  endtask : s_shorts

  initial begin
    reset_n = 1'b0;
    knob = '0;
    ramp = 8'h14;
    cfg_ovp_latch = 1'b0;
    cfg_uvp_long = 1'b0;
    miscompares = 0;
    n_checks = 0;
    s_startup();
    s_overtemp();
    s_demag_ov();
    s_demag_uv();
    s_supply_ov();
    s_overload();
    s_line();
    s_shorts();
    end_sim();
  end

  initial begin
    cyc(100000);
    miscompares++;
    end_sim();
  end
endmodule : testbench
